/* File: hw/apl_top.sv */
/*
  Angle output stage: periodic angle refresh, serial and SENT word latches,
  power-up shadow reload, APB register file and the open-drain pulse output.
  Assumes all pins synchronous to pclk (25 MHz) and an APB master on pclk.
*/
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "apl_params.svh"

module apl_top #(
  parameter int POWER_ON_CYCLES = 64
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] angle_raw,
  input  wire logic [3:0]  err_flags,
  input  wire logic [1:0]  nvm_serial_mode,
  input  wire logic        nvm_sent_wide,
  input  wire logic [2:0]  nvm_carrier_band,
  input  wire logic [3:0]  nvm_carrier_fine_step,
  input  wire logic [15:0] nvm_zero_offset,
  input  wire logic        ser_cs_n,
  input  wire logic        ser_sclk,
  input  wire logic        sent_latch,
  output logic [19:0]      ser_word,
  output logic [15:0]      sent_word,
  output logic             pwm_pin_o,
  output logic             pwm_pin_oe,
  output logic             init_done
);

  localparam int REFRESH_GAP = `APL_ANGLE_REFRESH_CYC;

  apl_pkg::apl_init_e     init_state_reg;
  apl_pkg::apl_init_e     init_state_next;
  apl_pkg::apl_ser_mode_e ser_mode_w;

  logic [19:0] init_cnt_reg;
  logic [`APL_REFRESH_CNT_W-1:0] refresh_cnt_reg;
  logic [15:0] angle_reg;
  logic [15:0] angle_adj_w;
  logic        refresh_tick;
  logic        run_w;
  logic        load_w;

  logic [1:0]  mode_reg;
  logic        sent_wide_reg;
  logic [7:0]  wadr_reg;
  logic [2:0]  band_reg;
  logic [3:0]  step_reg;
  logic [15:0] zero_reg;

  logic        sclk_prev_reg;
  logic        frame_latched_reg;
  logic        ser_latch_pulse;
  logic [19:0] ser_word_reg;
  logic [19:0] ser_word_next;
  logic [15:0] sent_word_reg;
  logic [15:0] sent_word_next;
  logic        sent_take_w;

  logic        pwm_level;
  logic [11:0] pwm_angle;

  logic [31:0] prdata_reg;
  logic [31:0] rdata_w;
  logic        setup_w;
  logic        access_w;
  logic        wr_w;
  logic        hit_cfg;
  logic        hit_pwm;
  logic        hit_zero;
  logic        hit_angle;
  logic        hit_serial;
  logic        hit_sent;
  logic        hit_status;
  logic        mapped_w;

  function automatic logic [3:0] apl_crc4(input logic [15:0] d);
    logic [3:0] c;
    logic       fb;
    c = `APL_CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      fb = c[3] ^ d[i];
      c  = {c[2:0], 1'b0} ^ (fb ? `APL_CRC_POLY : 4'h0);
    end
    return c;
  endfunction

  // Power-up sequence
  assign run_w  = (init_state_reg == apl_pkg::APL_INIT_RUN);
  assign load_w = (init_state_reg == apl_pkg::APL_INIT_LOAD);

  always_comb begin
    init_state_next = init_state_reg;
    unique case (init_state_reg)
      apl_pkg::APL_INIT_WAIT: begin
        if (init_cnt_reg == 20'(POWER_ON_CYCLES - 1)) begin
          init_state_next = apl_pkg::APL_INIT_LOAD;
        end
      end
      apl_pkg::APL_INIT_LOAD: begin
        init_state_next = apl_pkg::APL_INIT_RUN;
      end
      apl_pkg::APL_INIT_RUN: begin
        init_state_next = apl_pkg::APL_INIT_RUN;
      end
      default: begin
        init_state_next = apl_pkg::APL_INIT_WAIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_state_reg <= apl_pkg::APL_INIT_WAIT;
      init_cnt_reg   <= 20'h0;
    end else begin
      init_state_reg <= init_state_next;
      if (init_state_reg == apl_pkg::APL_INIT_WAIT) begin
        init_cnt_reg <= init_cnt_reg + 20'h1;
      end
    end
  end

  // APB decode
  assign setup_w    = psel && !penable;
  assign access_w   = psel && penable;
  assign hit_cfg    = (paddr == `APL_OFF_CFG);
  assign hit_pwm    = (paddr == `APL_OFF_PWM_CFG);
  assign hit_zero   = (paddr == `APL_OFF_ZERO);
  assign hit_angle  = (paddr == `APL_OFF_ANGLE);
  assign hit_serial = (paddr == `APL_OFF_SERIAL);
  assign hit_sent   = (paddr == `APL_OFF_SENT);
  assign hit_status = (paddr == `APL_OFF_STATUS);
  assign mapped_w   = hit_cfg || hit_pwm || hit_zero || hit_angle
                   || hit_serial || hit_sent || hit_status;
  // Writes ignored until power-up reload is done
  assign wr_w       = access_w && pwrite && mapped_w && run_w;
  assign pready     = 1'b1;
  assign pslverr    = access_w && !mapped_w;

  assign rdata_w =
      hit_cfg    ? (32'(mode_reg) << `APL_CFG_MODE_LSB)
                 | (32'(sent_wide_reg) << `APL_CFG_SENT_WIDE_BIT)
                 | (32'(wadr_reg) << `APL_CFG_WADR_LSB) :
      hit_pwm    ? (32'(band_reg) << `APL_PWM_BAND_LSB)
                 | (32'(step_reg) << `APL_PWM_STEP_LSB) :
      hit_zero   ? 32'(zero_reg) :
      hit_angle  ? 32'(angle_reg) :
      hit_serial ? 32'(ser_word_reg) :
      hit_sent   ? 32'(sent_word_reg) :
      hit_status ? (32'(run_w) << `APL_STAT_DONE_BIT)
                 | (32'(pwm_level) << `APL_STAT_LEVEL_BIT)
                 | (32'(pwm_angle) << `APL_STAT_PANG_LSB) :
                   32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_w) begin
      prdata_reg <= rdata_w;
    end
  end

  assign prdata = prdata_reg;

  // Shadow configuration: reset defaults, reload, then software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg      <= `APL_RST_MODE;
      sent_wide_reg <= 1'b0;
      wadr_reg      <= `APL_RST_WADR;
      band_reg      <= `APL_RST_BAND;
      step_reg      <= `APL_RST_STEP;
      zero_reg      <= `APL_RST_ZERO;
    end else if (load_w) begin
      mode_reg      <= nvm_serial_mode;
      sent_wide_reg <= nvm_sent_wide;
      band_reg      <= nvm_carrier_band;
      step_reg      <= nvm_carrier_fine_step;
      zero_reg      <= nvm_zero_offset;
    end else if (wr_w) begin
      if (hit_cfg) begin
        mode_reg      <= pwdata[`APL_CFG_MODE_LSB +: 2];
        sent_wide_reg <= pwdata[`APL_CFG_SENT_WIDE_BIT];
        wadr_reg      <= pwdata[`APL_CFG_WADR_LSB +: 8];
      end
      if (hit_pwm) begin
        band_reg <= pwdata[`APL_PWM_BAND_LSB +: 3];
        step_reg <= pwdata[`APL_PWM_STEP_LSB +: 4];
      end
      if (hit_zero) begin
        zero_reg <= pwdata[15:0];
      end
    end
  end

  // Angle refresh
  assign angle_adj_w  = angle_raw - zero_reg;
  assign refresh_tick = run_w
                     && (refresh_cnt_reg == `APL_REFRESH_CNT_W'(REFRESH_GAP - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_cnt_reg <= '0;
      angle_reg       <= 16'h0000;
    end else if (refresh_tick) begin
      refresh_cnt_reg <= '0;
      angle_reg       <= angle_adj_w;
    end else if (run_w) begin
      refresh_cnt_reg <= refresh_cnt_reg + `APL_REFRESH_CNT_W'(1);
    end
  end

  // Serial word latch on first clock edge of a frame
  assign ser_mode_w = apl_pkg::apl_ser_mode_e'(mode_reg);
  assign ser_latch_pulse = run_w && !ser_cs_n && (ser_sclk != sclk_prev_reg)
                        && !frame_latched_reg;

  always_comb begin
    ser_word_next = 20'h00000;
    unique case (ser_mode_w)
      apl_pkg::APL_SER_12_FLAGS: begin
        ser_word_next = {4'h0, err_flags, angle_reg[15:4]};
      end
      apl_pkg::APL_SER_15: begin
        ser_word_next = {5'h00, angle_reg[15:1]};
      end
      apl_pkg::APL_SER_20_CRC: begin
        ser_word_next = {angle_reg, apl_crc4(angle_reg)};
      end
      default: begin
        ser_word_next = {4'h0, err_flags, angle_reg[15:4]};
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev_reg     <= 1'b0;
      frame_latched_reg <= 1'b0;
      ser_word_reg      <= 20'h00000;
    end else begin
      sclk_prev_reg     <= ser_sclk;
      frame_latched_reg <= !ser_cs_n && (frame_latched_reg || ser_latch_pulse);
      if (ser_latch_pulse) begin
        ser_word_reg <= ser_word_next;
      end
    end
  end

  assign ser_word = ser_word_reg;

  // SENT angle packet
  assign sent_take_w    = run_w && sent_latch;
  assign sent_word_next = sent_wide_reg ? angle_reg : {4'h0, angle_reg[15:4]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_word_reg <= 16'h0000;
    end else if (sent_take_w) begin
      sent_word_reg <= sent_word_next;
    end
  end

  assign sent_word = sent_word_reg;

  // Pulse output
  apl_pwm_period u_pwm (
    .pclk         (pclk),
    .presetn      (presetn),
    .run          (run_w),
    .band         (band_reg),
    .step         (step_reg),
    .angle        (angle_reg[15:4]),
    .level        (pwm_level),
    .angle_held   (pwm_angle),
    .period_start ()
  );

  // Open drain: only ever pulls low
  assign pwm_pin_o  = 1'b0;
  assign pwm_pin_oe = !pwm_level;
  assign init_done  = run_w;

  sequence refresh_again;
    ##REFRESH_GAP refresh_tick;
  endsequence

  refresh_period_a : assert property (@(posedge pclk) disable iff (!presetn)
    refresh_tick |-> refresh_again)
    else $error("angle refresh interval wrong");

  refresh_value_a : assert property (@(posedge pclk) disable iff (!presetn)
    refresh_tick |=> angle_reg == $past(angle_adj_w))
    else $error("refreshed angle wrong");

  ser_once_a : assert property (@(posedge pclk) disable iff (!presetn)
    ser_latch_pulse ##1 !ser_cs_n |-> !ser_latch_pulse ##1 $stable(ser_word_reg))
    else $error("serial word relatched inside a frame");

  ser_flags_a : assert property (@(posedge pclk) disable iff (!presetn)
    ser_latch_pulse && (mode_reg == 2'h0) |=> ser_word_reg[15:12] == $past(err_flags))
    else $error("error flags missing from 12-bit word");

  ser_crc_a : assert property (@(posedge pclk) disable iff (!presetn)
    ser_latch_pulse && (mode_reg == 2'h2)
      |=> ser_word_reg[3:0] == apl_crc4(ser_word_reg[19:4]))
    else $error("serial check field wrong");

  sent_narrow_a : assert property (@(posedge pclk) disable iff (!presetn)
    sent_take_w && !sent_wide_reg |=> sent_word_reg[15:12] == 4'h0)
    else $error("narrow SENT packet has upper bits");

  reload_a : assert property (@(posedge pclk) disable iff (!presetn)
    load_w |=> (zero_reg == $past(nvm_zero_offset)) && init_done)
    else $error("shadow reload missing");

  wadr_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
    !run_w |-> wadr_reg == 8'h00)
    else $error("write address not cleared at power-up");

  unmapped_a : assert property (@(posedge pclk) disable iff (!presetn)
    access_w && !mapped_w |-> pslverr && pready)
    else $error("unmapped access not flagged");

endmodule

/* File: hw/apl_params.svh */
/*
  Constants for the angle output and pulse-width latch block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 25 MHz pclk; included by its bare name.
*/
`ifndef APL_PARAMS_SVH
`define APL_PARAMS_SVH

// Clock and timing
`define APL_CLK_KHZ            25000
`define APL_ANGLE_REFRESH_NS   2000
`define APL_ANGLE_REFRESH_CYC  ((`APL_ANGLE_REFRESH_NS * `APL_CLK_KHZ + 999999) / 1000000)
`define APL_REFRESH_CNT_W      6

// Register offsets (byte addresses)
`define APL_OFF_CFG            8'h00
`define APL_OFF_PWM_CFG        8'h04
`define APL_OFF_ZERO           8'h08
`define APL_OFF_ANGLE          8'h0C
`define APL_OFF_SERIAL         8'h10
`define APL_OFF_SENT           8'h14
`define APL_OFF_STATUS         8'h18

// Field positions
`define APL_CFG_MODE_LSB       0
`define APL_CFG_SENT_WIDE_BIT  2
`define APL_CFG_WADR_LSB       8
`define APL_PWM_BAND_LSB       0
`define APL_PWM_STEP_LSB       3
`define APL_STAT_DONE_BIT      0
`define APL_STAT_LEVEL_BIT     1
`define APL_STAT_PANG_LSB      16

// Reset values
`define APL_RST_MODE           2'h0
`define APL_RST_WADR           8'h00
`define APL_RST_BAND           3'h0
`define APL_RST_STEP           4'h0
`define APL_RST_ZERO           16'h0000

// Serial check field
`define APL_CRC_POLY           4'h3
`define APL_CRC_SEED           4'hF

// Carrier period grid, in microseconds and derived cycles
`define APL_PWM_BASE_US        320
`define APL_PWM_BAND_US        40
`define APL_PWM_BASE_CYC       (`APL_PWM_BASE_US * `APL_CLK_KHZ / 1000)
`define APL_PWM_BAND_CYC       (`APL_PWM_BAND_US * `APL_CLK_KHZ / 1000)
`define APL_PWM_FINE_HALF_CYC  125
`define APL_PWM_LEAD_PCT       5
`define APL_PWM_SPAN_PCT       90
`define APL_ANGLE_STEPS        4096

`endif

/* File: hw/apl_pkg.sv */
/*
  Types shared by the angle output and pulse-width latch block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package apl_pkg;

  typedef enum logic [1:0] {
    APL_SER_12_FLAGS,
    APL_SER_15,
    APL_SER_20_CRC
  } apl_ser_mode_e;

  typedef enum logic [1:0] {
    APL_INIT_WAIT,
    APL_INIT_LOAD,
    APL_INIT_RUN
  } apl_init_e;

endpackage

/* File: hw/apl_pwm_period.sv */
/*
  Carrier period counter and duty generator for the pulse-width output.
  Assumes band, step and angle come from pclk-domain registers.
*/
`timescale 1ns/100ps
`include "apl_params.svh"

module apl_pwm_period (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic [2:0]  band,
  input  wire logic [3:0]  step,
  input  wire logic [11:0] angle,
  output logic             level,
  output logic [11:0]      angle_held,
  output logic             period_start
);

  logic [17:0] period_reg;
  logic [17:0] count_reg;
  logic [11:0] angle_reg;
  logic        level_reg;
  logic [23:0] band_pow_w;
  logic [23:0] period_w;
  logic [39:0] high_w;
  logic        wrap_w;

  assign band_pow_w = 24'h1 << band;
  // Period from band and fine step
  assign period_w = 24'(`APL_PWM_BASE_CYC)
                  + 24'(`APL_PWM_BAND_CYC) * (band_pow_w - 24'h1)
                  + ((24'(`APL_PWM_FINE_HALF_CYC) * 24'(step) * band_pow_w) >> 1);
  // High time: lead-in plus angle share of the middle span
  assign high_w = (40'(period_reg)
                   * (40'(`APL_PWM_LEAD_PCT * `APL_ANGLE_STEPS)
                      + 40'(`APL_PWM_SPAN_PCT) * 40'(angle_reg)))
                  / 40'(100 * `APL_ANGLE_STEPS);
  assign wrap_w = !run || (count_reg == period_reg - 18'h1);
  assign period_start = run && (count_reg == 18'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_reg <= 18'(`APL_PWM_BASE_CYC);
      count_reg  <= 18'h0;
      angle_reg  <= 12'h000;
    end else if (wrap_w) begin
      count_reg  <= 18'h0;
      period_reg <= period_w[17:0];
      angle_reg  <= angle;
    end else begin
      count_reg  <= count_reg + 18'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= run && (40'(count_reg) < high_w);
    end
  end

  assign level = level_reg;
  assign angle_held = angle_reg;

  lead_high_a : assert property (@(posedge pclk) disable iff (!presetn)
    run && !wrap_w && (count_reg < period_reg / 18'h14) |=> level_reg)
    else $error("output not high in lead-in");

  tail_low_a : assert property (@(posedge pclk) disable iff (!presetn)
    (count_reg >= period_reg - period_reg / 18'h14) |=> !level_reg)
    else $error("output not low in tail");

  angle_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
    !wrap_w |=> $stable(angle_reg))
    else $error("angle changed inside a period");

  period_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
    !wrap_w |=> $stable(period_reg))
    else $error("period changed mid period");

endmodule

/* File: tb/apl_host_model.sv */
/*
  Host model: clocks serial readout frames and times the pulse output line.
  Assumes pins sampled on pclk and a pulled-up open-drain pulse line.
*/
`timescale 1ns/100ps

module apl_host_model (
  input  wire logic pclk,
  input  wire logic pwm_line,
  output logic      ser_cs_n,
  output logic      ser_sclk
);
  initial begin
    ser_cs_n = 1'b1;
    ser_sclk = 1'b0;
  end

  // Sixteen full clocks, sclk idle before select falls
  task automatic frame();
    int i;
    @(posedge pclk);
    ser_cs_n <= 1'b0;
    for (i = 0; i < 32; i++) begin
      repeat (2) @(posedge pclk);
      ser_sclk <= ~ser_sclk;
    end
    @(posedge pclk);
    ser_cs_n <= 1'b1;
    @(posedge pclk);
  endtask

  // High and period cycle counts, rising edge to rising edge
  task automatic measure(output int hi, output int per);
    logic last;
    hi = 0;
    per = 0;
    do @(posedge pclk); while (pwm_line !== 1'b0);
    do @(posedge pclk); while (pwm_line !== 1'b1);
    do begin
      if (pwm_line === 1'b1) hi++;
      per++;
      last = pwm_line;
      @(posedge pclk);
    end while (!(last === 1'b0 && pwm_line === 1'b1));
  endtask
endmodule

/* File: tb/apl_top_tb.sv */
/*
  Self-checking bench for apl_top: APB register access, serial and SENT
  latches, power-up reload and pulse output timing.
  Assumes a 25 MHz pclk and the host model in apl_host_model.sv.
*/
`timescale 1ns/100ps
`include "apl_params.svh"

module apl_top_tb;
  localparam int PON = 4;
  logic        pclk, presetn, psel, penable, pwrite, sent_latch, nvm_sent_wide;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, pwm_pin_o, pwm_pin_oe, init_done, ser_cs_n, ser_sclk, e;
  logic [15:0] angle_raw, nvm_zero_offset, sent_word, ang;
  logic [3:0]  err_flags, nvm_carrier_fine_step;
  logic [1:0]  nvm_serial_mode;
  logic [2:0]  nvm_carrier_band;
  logic [19:0] ser_word;
  wire         pwm_line = pwm_pin_oe ? pwm_pin_o : 1'b1;
  int          n_mismatch, n_tests, m, hi, per;

  apl_top #(.POWER_ON_CYCLES(PON)) uut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .angle_raw, .err_flags,
    .nvm_serial_mode, .nvm_sent_wide, .nvm_carrier_band, .nvm_carrier_fine_step,
    .nvm_zero_offset, .ser_cs_n, .ser_sclk, .sent_latch, .ser_word, .sent_word,
    .pwm_pin_o, .pwm_pin_oe, .init_done);
  apl_host_model host (.pclk, .pwm_line, .ser_cs_n, .ser_sclk);

  always #20 pclk = ~pclk;

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), q, exp);
  endtask

  task automatic reset_run();
    int i;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("oe in reset", {31'h0, pwm_pin_oe}, 32'h1);
    chk("serial in reset", {12'h000, ser_word}, 32'h0);
    presetn <= 1'b1;
    wr(`APL_OFF_CFG, 32'h0000_A501);
    for (i = 0; i < 50 && init_done !== 1'b1; i++) @(posedge pclk);
    chk("init done", {31'h0, init_done}, 32'h1);
  endtask

  function automatic logic [3:0] crc4(input logic [15:0] d);
    logic [3:0] c;
    c = 4'hF;
    for (int i = 15; i >= 0; i--)
      c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h3 : 4'h0);
    return c;
  endfunction

  function automatic logic [19:0] ser_exp(input int md, input logic [15:0] a);
    case (md)
      1:       return {5'h00, a[15:1]};
      2:       return {a, crc4(a)};
      default: return {4'h0, err_flags, a[15:4]};
    endcase
  endfunction

  // High cycles for period p and 12-bit angle a
  function automatic int hexp(input longint p, input longint a);
    return int'((p * (20480 + 90 * a)) / 409600);
  endfunction

  initial begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; sent_latch = 1'b0; err_flags = 4'hA;
    angle_raw = 16'h8010; nvm_serial_mode = 2'h2; nvm_sent_wide = 1'b1;
    nvm_carrier_band = 3'h0; nvm_carrier_fine_step = 4'h0; nvm_zero_offset = 16'h0010;
    reset_run();
    rdchk(`APL_OFF_CFG, 32'h0000_0006);
    rdchk(`APL_OFF_PWM_CFG, 32'h0000_0000);
    rdchk(`APL_OFF_ZERO, 32'h0000_0010);
    rdchk(8'h1C, 32'h0000_0000);
    chk("unmapped error", {31'h0, e}, 32'h1);
    repeat (51) @(posedge pclk);
    rdchk(`APL_OFF_ANGLE, 32'h0000_8000);
    for (m = 0; m < 4; m++) begin
      wr(`APL_OFF_CFG, 32'(m));
      repeat (52) @(posedge pclk);
      ang = angle_raw - 16'h0010;
      fork
        host.frame();
        begin
          repeat (6) @(posedge pclk);
          angle_raw <= ~angle_raw;
        end
      join
      chk("serial word", {12'h000, ser_word}, {12'h000, ser_exp(m, ang)});
      rdchk(`APL_OFF_SERIAL, {12'h000, ser_exp(m, ang)});
    end
    ang = angle_raw - 16'h0010;
    for (m = 0; m < 2; m++) begin
      wr(`APL_OFF_CFG, 32'(m) << 2);
      @(posedge pclk);
      sent_latch <= 1'b1;
      @(posedge pclk);
      sent_latch <= 1'b0;
      @(posedge pclk);
      chk("sent word", {16'h0, sent_word}, m ? {16'h0, ang} : {20'h0, ang[15:4]});
    end
    chk("open drain data", {31'h0, pwm_pin_o}, 32'h0);
    angle_raw <= 16'h0010;
    repeat (52) @(posedge pclk);
    // Angle and carrier change land inside the measured period
    fork
      host.measure(hi, per);
      begin
        do @(posedge pclk); while (pwm_line !== 1'b0);
        do @(posedge pclk); while (pwm_line !== 1'b1);
        repeat (100) @(posedge pclk);
        angle_raw <= 16'h000F;
        wr(`APL_OFF_PWM_CFG, 32'h0000_0009);
      end
    join
    chk("period band0", per, 8000);
    chk("high at zero", hi, hexp(8000, 0));
    host.measure(hi, per);
    chk("period band1 step1", per, 9125);
    chk("high at max", hi, hexp(9125, 4095));
    apb(1'b0, `APL_OFF_STATUS, 32'h0);
    chk("held angle", q & 32'h0FFF_0001, 32'h0FFF_0001);
    wr(`APL_OFF_CFG, 32'h0000_5A01);
    rdchk(`APL_OFF_CFG, 32'h0000_5A01);
    nvm_serial_mode <= 2'h1;
    nvm_sent_wide <= 1'b0;
    nvm_carrier_band <= 3'h2;
    reset_run();
    rdchk(`APL_OFF_CFG, 32'h0000_0001);
    rdchk(`APL_OFF_PWM_CFG, 32'h0000_0002);
    wrap_up();
  end
endmodule
